// ==== rtl/ctrl_bus_pkg.sv ====
// constants and types shared by the control-channel bus configuration block
package ctrl_bus_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BUS_CTRL_TWO = 8'h06; // bus control two
  localparam logic [7:0] OFS_REMOTE_IDENT = 8'h07; // remote serializer id
  localparam logic [7:0] OFS_TGT_ADDR_0   = 8'h08; // remote target address 0
  localparam logic [7:0] OFS_TGT_ADDR_1   = 8'h09; // remote target address 1
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int BIT_SEQ_ERR     = 7; // sequence-error flag
  localparam int BIT_SEQ_CLR     = 6; // sequence-error clear
  localparam int BIT_DLY_HI      = 4; // sda delay field msb
  localparam int BIT_DLY_LO      = 3; // sda delay field lsb
  localparam int BIT_LWR_BLOCK   = 2; // block remote writes
  localparam int BIT_WD_FAST     = 1; // watchdog speedup
  localparam int BIT_WD_OFF      = 0; // watchdog disable
  localparam int BIT_HOLD_IDENT  = 0; // freeze remote_serializer_ident
  localparam int ADDR_HI         = 7; // 7-bit address field msb
  localparam int ADDR_LO         = 1; // 7-bit address field lsb
  localparam logic [7:0] RST_BUS_CTRL_TWO = 8'h00; // bus control reset
  localparam logic [7:0] RST_REMOTE_IDENT = 8'h00; // remote_serializer_ident reset
  localparam logic [6:0] RST_TGT_ADDR     = 7'h00; // target address reset
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 200;  // system clock rate
  localparam int CLK_PERIOD_NS  = 5;    // system clock period
  localparam int WD_LONG_S      = 1;    // slow watchdog period
  localparam int WD_SHORT_US    = 50;   // fast watchdog period
  localparam int WD_LONG_CYC    = WD_LONG_S * CLK_MHZ * 1000000;
  localparam int WD_SHORT_CYC   = WD_SHORT_US * CLK_MHZ;
  localparam int SDA_DLY_BASE_NS = 250; // delay at code 00
  localparam int SDA_DLY_STEP_NS = 50;  // delay per code step
  localparam int SDA_DLY_BASE_CYC = SDA_DLY_BASE_NS / CLK_PERIOD_NS;
  localparam int SDA_DLY_STEP_CYC = SDA_DLY_STEP_NS / CLK_PERIOD_NS;
  localparam int RECOV_HALF_NS  = 5000; // recovery scl half period
  localparam int RECOV_HALF_CYC = RECOV_HALF_NS / CLK_PERIOD_NS;
  localparam int RECOV_PULSES   = 9;    // clocks driven on a hung bus
  // ---------------------------------------------------------------
  // watchdog states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {WD_WATCH, WD_RECOV_LOW, WD_RECOV_HIGH} wd_state_t;
endpackage : ctrl_bus_pkg

// ==== rtl/bus_watchdog.sv ====
// bus watchdog: idle detection and hung-bus recovery clocks
`timescale 1ns/100ps
module bus_watchdog
  import ctrl_bus_pkg::*;
#(
  parameter int CNT_W     = 28,             // timeout counter width
  parameter int LONG_CYC  = WD_LONG_CYC,    // slow timeout in cycles
  parameter int SHORT_CYC = WD_SHORT_CYC    // fast timeout in cycles
)(
  input  wire logic sys_clk,   // system clock
  input  wire logic rstn,      // synchronous reset, active low
  input  wire logic wd_off,    // timer disabled
  input  wire logic wd_fast,   // short timeout selected
  input  wire logic scl_in,    // scl pin level
  input  wire logic sda_in,    // sda pin level
  output logic      scl_oe_n,  // scl driven low when 0
  output logic      bus_free   // one-cycle pulse, bus judged free
);
  import ctrl_bus_pkg::*;

  if (LONG_CYC >= 2**CNT_W || SHORT_CYC >= 2**CNT_W || SHORT_CYC < 1)
    $error("bus_watchdog: timeout does not fit counter");

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    wd_state_t      st;     // watch or recovery phase
    logic [CNT_W-1:0] cnt;  // quiet-time counter
    logic [9:0]     half;   // recovery half-period counter
    logic [3:0]     pulses; // recovery clocks issued
    logic           scl_q;  // previous scl
    logic           sda_q;  // previous sda
    logic           oe_n;   // scl drive enable, low drives
    logic           free;   // bus-free pulse
  } wd_t;

  wd_t cur_ff;  // registered state
  wd_t nxt_st;  // next state

  logic [CNT_W-1:0] limit;  // active timeout
  assign limit = wd_fast ? CNT_W'(SHORT_CYC - 1) : CNT_W'(LONG_CYC - 1);

  // next-state logic
  always_comb
  begin
    nxt_st       = cur_ff;
    nxt_st.scl_q = scl_in;
    nxt_st.sda_q = sda_in;
    nxt_st.free  = 1'b0;
    case (cur_ff.st)
      WD_WATCH:
      begin
        // any edge on either line restarts the quiet time
        if (wd_off || scl_in != cur_ff.scl_q || sda_in != cur_ff.sda_q)
          nxt_st.cnt = '0;
        else if (cur_ff.cnt >= limit)
        begin
          nxt_st.cnt = '0;
          if (sda_in)
            nxt_st.free = 1'b1;
          else
          begin
            nxt_st.st     = WD_RECOV_LOW;
            nxt_st.oe_n   = 1'b0;
            nxt_st.half   = '0;
            nxt_st.pulses = '0;
          end
        end
        else
          nxt_st.cnt = cur_ff.cnt + 1'b1;
      end
      WD_RECOV_LOW:
      begin
        // scl held low for one half period
        if (cur_ff.half == 10'(RECOV_HALF_CYC - 1))
        begin
          nxt_st.half = '0;
          nxt_st.oe_n = 1'b1;
          nxt_st.st   = WD_RECOV_HIGH;
        end
        else
          nxt_st.half = cur_ff.half + 1'b1;
      end
      WD_RECOV_HIGH:
      begin
        // scl released; count the finished clock
        if (cur_ff.half == 10'(RECOV_HALF_CYC - 1))
        begin
          nxt_st.half   = '0;
          nxt_st.pulses = cur_ff.pulses + 1'b1;
          if (cur_ff.pulses == 4'(RECOV_PULSES - 1))
            nxt_st.st = WD_WATCH;
          else
          begin
            nxt_st.oe_n = 1'b0;
            nxt_st.st   = WD_RECOV_LOW;
          end
        end
        else
          nxt_st.half = cur_ff.half + 1'b1;
      end
      default:
        nxt_st.st = WD_WATCH;
    endcase
    // disabling aborts any recovery
    if (wd_off && cur_ff.st != WD_WATCH)
    begin
      nxt_st.st   = WD_WATCH;
      nxt_st.oe_n = 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cur_ff       <= '0;
      cur_ff.st    <= WD_WATCH;
      cur_ff.scl_q <= 1'b1;
      cur_ff.sda_q <= 1'b1;
      cur_ff.oe_n  <= 1'b1;
    end
    else
      cur_ff <= nxt_st;
  end

  assign scl_oe_n = cur_ff.oe_n;
  assign bus_free = cur_ff.free;
endmodule : bus_watchdog

// ==== rtl/ctrl_channel_bus_config.sv ====
// control-channel bus configuration, status and address remapping
// ---------------------------------------------------------------
// Summary of operation
// - forward-channel sequence error sets status bit 7
// - bit 6 clears flag; software returns it
// - bits 4:3 pick SDA delay 250-400ns
// - bit 2 blocks remote writes to registers
// - watchdog near 1s, or 50us when bit 1
// - bit 0 disables watchdog and its actions
// - quiet bus with SDA high is free
// - quiet bus with SDA low gets nine clocks
// - freeze clear: remote_serializer_ident auto-loads, read-only
// - freeze set: ID bits writable and kept
// - alias slot 0 remapped to address 0x08
// - alias slot 1 remapped to address 0x09
// - pass-through forwards alias matches to serializer
// ---------------------------------------------------------------
`timescale 1ns/100ps
module ctrl_channel_bus_config
  import ctrl_bus_pkg::*;
#(
  parameter int WD_CNT_W   = 28,           // watchdog counter width
  parameter int WD_LONG    = WD_LONG_CYC,  // slow watchdog cycles
  parameter int WD_SHORT   = WD_SHORT_CYC  // fast watchdog cycles
)(
  input  wire logic       sys_clk,        // system clock
  input  wire logic       rstn,           // synchronous reset, active low
  input  wire logic [7:0] reg_addr,       // register offset
  input  wire logic [7:0] reg_wdata,      // register write data
  input  wire logic       reg_wr,         // register write strobe
  input  wire logic       reg_wr_remote,  // write came from the serializer
  input  wire logic       reg_rd,         // register read strobe
  output logic [7:0]      reg_rdata,      // read data, cycle after reg_rd
  output logic            reg_wr_refused, // pulse, remote write dropped
  input  wire logic       seq_err_evt,    // forward channel sequence error
  input  wire logic       rid_valid,      // remote_serializer_ident update from link
  input  wire logic [6:0] rid_value,      // remote_serializer_ident from link
  input  wire logic       pass_through,   // pass-through mode enabled
  input  wire logic [6:0] target_alias_slot_0, // alias address slot 0
  input  wire logic [6:0] target_alias_slot_1, // alias address slot 1
  input  wire logic       txn_valid,      // local transaction address valid
  input  wire logic [6:0] txn_addr,       // local transaction address
  output logic            fwd_valid,      // pulse, forward to serializer
  output logic [6:0]      fwd_addr,       // remapped target address
  input  wire logic       sda_tx_en,      // target logic drives sda
  input  wire logic       sda_tx_bit,     // bit target logic sends
  input  wire logic       scl_in,         // scl pin level
  output logic            scl_out,        // scl pin drive value
  output logic            scl_oe_n,       // scl driven when low
  input  wire logic       sda_in,         // sda pin level
  output logic            sda_out,        // sda pin drive value
  output logic            sda_oe_n,       // sda driven when low
  output logic            bus_free        // pulse, idle bus judged free
);
  import ctrl_bus_pkg::*;

  if (WD_CNT_W < 14 || WD_CNT_W > 31)
    $error("ctrl_channel_bus_config: watchdog counter width unsupported");

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;     // bus control two
    logic [6:0] rid;      // remote serializer id
    logic       hold;     // freeze remote_serializer_ident
    logic [6:0] tgt0;     // target_phys_addr_0
    logic [6:0] tgt1;     // target_phys_addr_1
    logic [7:0] rdata;    // read data
    logic       refused;  // refused-write pulse
    logic       fvalid;   // forward pulse
    logic [6:0] faddr;    // forward address
    logic       scl_q;    // previous scl
    logic [6:0] dly;      // sda delay countdown
    logic       dly_run;  // delay in progress
    logic       sda_oe_n; // sda drive enable
    logic       drv_lvl;  // pin drive value, always low
  } cfg_t;

  cfg_t cur_ff;  // registered state
  cfg_t nxt_st;  // next state

  logic       wr_ok;    // write accepted
  logic [6:0] dly_cyc;  // delay for current code
  logic       wd_scl_oe_n; // watchdog scl enable
  logic       wd_free;     // watchdog free pulse

  // remote writes are dropped when blocked
  assign wr_ok = reg_wr && !(reg_wr_remote && cur_ff.ctrl[BIT_LWR_BLOCK]);

  // delay = base + code * step
  assign dly_cyc = 7'(SDA_DLY_BASE_CYC) +
                   7'(cur_ff.ctrl[BIT_DLY_HI:BIT_DLY_LO]) * 7'(SDA_DLY_STEP_CYC);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st         = cur_ff;
    nxt_st.refused = reg_wr && !wr_ok;
    nxt_st.fvalid  = 1'b0;
    nxt_st.scl_q   = scl_in;
    nxt_st.drv_lvl = 1'b0;

    // register writes
    if (wr_ok)
    begin
      case (reg_addr)
        OFS_BUS_CTRL_TWO:
        begin
          // flag bit is hardware owned, bit 5 reserved
          nxt_st.ctrl[BIT_SEQ_CLR]           = reg_wdata[BIT_SEQ_CLR];
          nxt_st.ctrl[BIT_DLY_HI:BIT_DLY_LO] = reg_wdata[BIT_DLY_HI:BIT_DLY_LO];
          nxt_st.ctrl[BIT_LWR_BLOCK]         = reg_wdata[BIT_LWR_BLOCK];
          nxt_st.ctrl[BIT_WD_FAST]           = reg_wdata[BIT_WD_FAST];
          nxt_st.ctrl[BIT_WD_OFF]            = reg_wdata[BIT_WD_OFF];
        end
        OFS_REMOTE_IDENT:
        begin
          nxt_st.hold = reg_wdata[BIT_HOLD_IDENT];
          if (reg_wdata[BIT_HOLD_IDENT])
            nxt_st.rid = reg_wdata[ADDR_HI:ADDR_LO];
        end
        OFS_TGT_ADDR_0:
          nxt_st.tgt0 = reg_wdata[ADDR_HI:ADDR_LO];
        OFS_TGT_ADDR_1:
          nxt_st.tgt1 = reg_wdata[ADDR_HI:ADDR_LO];
        default:
          ; // unmapped: ignored
      endcase
    end

    // auto-load of remote_serializer_ident while not frozen
    if (rid_valid && !cur_ff.hold && !(wr_ok && reg_addr == OFS_REMOTE_IDENT
                                       && reg_wdata[BIT_HOLD_IDENT]))
      nxt_st.rid = rid_value;

    // sequence-error flag: clear bit holds it low, else events set it
    if (nxt_st.ctrl[BIT_SEQ_CLR])
      nxt_st.ctrl[BIT_SEQ_ERR] = 1'b0;
    else if (seq_err_evt)
      nxt_st.ctrl[BIT_SEQ_ERR] = 1'b1;

    // register reads, unmapped reads return zero
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_BUS_CTRL_TWO: nxt_st.rdata = cur_ff.ctrl;
        OFS_REMOTE_IDENT: nxt_st.rdata = {cur_ff.rid, cur_ff.hold};
        OFS_TGT_ADDR_0:   nxt_st.rdata = {cur_ff.tgt0, 1'b0};
        OFS_TGT_ADDR_1:   nxt_st.rdata = {cur_ff.tgt1, 1'b0};
        default:          nxt_st.rdata = 8'h00;
      endcase
    end

    // alias matching and remap for pass-through
    if (txn_valid && pass_through)
    begin
      if (txn_addr == target_alias_slot_0)
      begin
        nxt_st.fvalid = 1'b1;
        nxt_st.faddr  = cur_ff.tgt0;
      end
      else if (txn_addr == target_alias_slot_1)
      begin
        nxt_st.fvalid = 1'b1;
        nxt_st.faddr  = cur_ff.tgt1;
      end
    end

    // sda output delayed after each scl falling edge
    if (cur_ff.scl_q && !scl_in)
    begin
      nxt_st.dly_run = 1'b1;
      nxt_st.dly     = dly_cyc - 7'h01;
    end
    else if (cur_ff.dly_run)
    begin
      if (cur_ff.dly == 7'h00)
      begin
        nxt_st.dly_run  = 1'b0;
        nxt_st.sda_oe_n = !(sda_tx_en && !sda_tx_bit);
      end
      else
        nxt_st.dly = cur_ff.dly - 7'h01;
    end
    else if (!sda_tx_en)
      nxt_st.sda_oe_n = 1'b1; // release when target logic lets go
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cur_ff          <= '0;
      cur_ff.ctrl     <= RST_BUS_CTRL_TWO;
      cur_ff.rid      <= RST_REMOTE_IDENT[ADDR_HI:ADDR_LO];
      cur_ff.hold     <= RST_REMOTE_IDENT[BIT_HOLD_IDENT];
      cur_ff.tgt0     <= RST_TGT_ADDR;
      cur_ff.tgt1     <= RST_TGT_ADDR;
      cur_ff.scl_q    <= 1'b1;
      cur_ff.sda_oe_n <= 1'b1;
    end
    else
      cur_ff <= nxt_st;
  end

  // ---------------------------------------------------------------
  // bus watchdog
  // ---------------------------------------------------------------
  bus_watchdog #(
    .CNT_W     (WD_CNT_W),
    .LONG_CYC  (WD_LONG),
    .SHORT_CYC (WD_SHORT)
  ) u_wd (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .wd_off   (cur_ff.ctrl[BIT_WD_OFF]),
    .wd_fast  (cur_ff.ctrl[BIT_WD_FAST]),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .scl_oe_n (wd_scl_oe_n),
    .bus_free (wd_free)
  );

  // outputs
  assign reg_rdata      = cur_ff.rdata;
  assign reg_wr_refused = cur_ff.refused;
  assign fwd_valid      = cur_ff.fvalid;
  assign fwd_addr       = cur_ff.faddr;
  assign sda_oe_n       = cur_ff.sda_oe_n;
  assign sda_out        = cur_ff.drv_lvl;
  assign scl_out        = cur_ff.drv_lvl;
  assign scl_oe_n       = wd_scl_oe_n;
  assign bus_free       = wd_free;
endmodule : ctrl_channel_bus_config

// ==== test/ctrl_channel_bus_config_sva.sv ====
// assertions for the control-channel bus configuration block
`timescale 1ns/100ps
module ctrl_bus_chk
  import ctrl_bus_pkg::*;
(
  input wire logic       sys_clk,             // clock
  input wire logic       rstn,                // reset, active low
  input wire logic [7:0] reg_addr,            // offset
  input wire logic [7:0] reg_wdata,           // write data
  input wire logic       reg_wr,              // write strobe
  input wire logic       reg_wr_remote,       // write from serializer
  input wire logic       reg_rd,              // read strobe
  input wire logic [7:0] reg_rdata,           // read data
  input wire logic       reg_wr_refused,      // refused pulse
  input wire logic       pass_through,        // pass-through level
  input wire logic [6:0] target_alias_slot_0, // alias 0
  input wire logic [6:0] target_alias_slot_1, // alias 1
  input wire logic       txn_valid,           // transaction strobe
  input wire logic [6:0] txn_addr,            // transaction address
  input wire logic       fwd_valid,           // forward pulse
  input wire logic [6:0] fwd_addr,            // forward address
  input wire logic       scl_oe_n,            // scl pulled when low
  input wire logic       bus_free             // free pulse
);
  logic [7:0] ctl_ff;  // shadow of bus control
  logic [6:0] tgt0_ff; // shadow of target 0
  logic [6:0] tgt1_ff; // shadow of target 1
  logic       acc;     // write not blocked
  assign acc = reg_wr && !(reg_wr_remote && ctl_ff[2]);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // shadows follow accepted writes only
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctl_ff  <= 8'h00;
      tgt0_ff <= 7'h00;
      tgt1_ff <= 7'h00;
    end
    else if (acc)
    begin
      if (reg_addr == OFS_BUS_CTRL_TWO) ctl_ff <= reg_wdata;
      if (reg_addr == OFS_TGT_ADDR_0) tgt0_ff <= reg_wdata[7:1];
      if (reg_addr == OFS_TGT_ADDR_1) tgt1_ff <= reg_wdata[7:1];
    end
  end
  chk_refuse_pulse: assert property (reg_wr && reg_wr_remote && ctl_ff[2] |=> reg_wr_refused)
    else $error("blocked remote write not flagged");
  chk_refuse_none: assert property (!(reg_wr && reg_wr_remote && ctl_ff[2]) |=> !reg_wr_refused)
    else $error("refusal without blocked write");
  chk_fwd_slot0: assert property (txn_valid && pass_through && txn_addr == target_alias_slot_0
    |=> fwd_valid && fwd_addr == $past(tgt0_ff))
    else $error("slot 0 not remapped");
  chk_fwd_slot1: assert property (txn_valid && pass_through && txn_addr == target_alias_slot_1
    && txn_addr != target_alias_slot_0 |=> fwd_valid && fwd_addr == $past(tgt1_ff))
    else $error("slot 1 not remapped");
  chk_fwd_idle: assert property (!(txn_valid && pass_through && (txn_addr == target_alias_slot_0
    || txn_addr == target_alias_slot_1)) |=> !fwd_valid)
    else $error("forward without alias match");
  chk_alias_lsb: assert property (reg_rd && reg_addr[7:1] == 7'h04 |=> !reg_rdata[0])
    else $error("alias bit 0 not zero");
  chk_flag_held: assert property (reg_rd && reg_addr == OFS_BUS_CTRL_TWO && ctl_ff[6]
    |=> !reg_rdata[7])
    else $error("flag set while clear bit high");
  chk_wd_off: assert property (ctl_ff[0] |=> scl_oe_n && !bus_free)
    else $error("watchdog acts while disabled");
  chk_recov_low: assert property ($fell(scl_oe_n) && !ctl_ff[0]
    |=> (!scl_oe_n || ctl_ff[0]) [*8])
    else $error("recovery clock low too short");
endmodule : ctrl_bus_chk
bind ctrl_channel_bus_config ctrl_bus_chk chk_i (.sys_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_wr_remote, .reg_rd, .reg_rdata, .reg_wr_refused, .pass_through,
  .target_alias_slot_0, .target_alias_slot_1, .txn_valid, .txn_addr, .fwd_valid, .fwd_addr,
  .scl_oe_n, .bus_free);

// ==== test/i2c_bus_model.sv ====
// two-wire bus with pull-ups and a host that may hold either line low
`timescale 1ns/100ps
module i2c_bus_model (
  input wire logic scl_oe_n, // device pulls scl when low
  input wire logic sda_oe_n, // device pulls sda when low
  input wire logic host_scl, // host pulls scl low
  input wire logic host_sda, // host holds sda low, hung bus
  output logic     scl_line, // resolved scl level
  output logic     sda_line  // resolved sda level
);
  // wired-and: a released line floats up to its pull-up
  assign scl_line = !(host_scl || !scl_oe_n);
  assign sda_line = !(host_sda || !sda_oe_n);
endmodule : i2c_bus_model

// ==== test/ctrl_channel_bus_config_tb.sv ====
// self-checking bench for the control-channel bus configuration block
`timescale 1ns/100ps
module ctrl_channel_bus_config_tb;
  import ctrl_bus_pkg::*;
  localparam int SHORT = 20; // shortened fast timeout
  localparam int LONG  = 40; // shortened slow timeout
  logic       sys_clk = 1'b0, rstn = 1'b0;
  logic       reg_wr, reg_wr_remote, reg_rd, reg_wr_refused, seq_err_evt, rid_valid;
  logic       pass_through, txn_valid, fwd_valid, sda_tx_en, sda_tx_bit, scl_in, sda_in;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, bus_free, host_scl, host_sda;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [6:0] rid_value, alias0, alias1, txn_addr, fwd_addr;
  int         err_count = 0, samples_checked = 0, n;
  int         m_ctl = 0, m_flag = 0, m_rid = 0, m_hold = 0, m_tgt[2] = '{0, 0};
  always #2.5 sys_clk = ~sys_clk;
  ctrl_channel_bus_config #(.WD_LONG(LONG), .WD_SHORT(SHORT)) uut (.sys_clk, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .reg_wr_remote, .reg_rd, .reg_rdata, .reg_wr_refused,
    .seq_err_evt, .rid_valid, .rid_value, .pass_through, .target_alias_slot_0(alias0),
    .target_alias_slot_1(alias1), .txn_valid, .txn_addr, .fwd_valid, .fwd_addr, .sda_tx_en,
    .sda_tx_bit, .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .bus_free);
  i2c_bus_model bus_i (.scl_oe_n, .sda_oe_n, .host_scl, .host_sda, .scl_line(scl_in),
    .sda_line(sda_in));
  // ---------------------------------------------------------------
  // compare tasks and the closing report
  // ---------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8
  task automatic checkn(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s took %0d cycles", $time, what, got);
    end
  endtask : checkn
  // bounded wait: 0 free, 1 scl low, 2 sda low, 3 scl high, 4 sda high
  task automatic wait_for(input int s, input int bound, output int cnt);
    cnt = 0;
    while (!(s == 0 ? bus_free === 1'b1 : s == 1 ? scl_oe_n === 1'b0 :
             s == 2 ? sda_oe_n === 1'b0 : s == 3 ? scl_oe_n === 1'b1 : sda_oe_n === 1'b1))
    begin
      if (cnt == bound)
      begin
        err_count++;
        $display("CHECK FAILED at %0t: wait timed out", $time);
        results();
      end
      @(posedge sys_clk) #1;
      cnt++;
    end
  endtask : wait_for
  // ---------------------------------------------------------------
  // register bus with the reference model beside it
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
    logic blk;
    blk = rem && m_ctl[2];
    @(posedge sys_clk) #1;
    {reg_wr, reg_addr, reg_wdata, reg_wr_remote} = {1'b1, a, d, rem};
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    check8({7'h0, reg_wr_refused}, {7'h0, blk}, "refused");
    if (blk) return;
    if (a == OFS_BUS_CTRL_TWO) m_ctl = d & 8'h5f;
    if (a == OFS_REMOTE_IDENT && d[0]) m_rid = d[7:1];
    if (a == OFS_REMOTE_IDENT) m_hold = d[0];
    if (a == OFS_TGT_ADDR_0) m_tgt[0] = d[7:1];
    if (a == OFS_TGT_ADDR_1) m_tgt[1] = d[7:1];
    if (m_ctl[6]) m_flag = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = a == OFS_BUS_CTRL_TWO ? {m_flag[0], m_ctl[6:0]} : a == OFS_REMOTE_IDENT ?
        {m_rid[6:0], m_hold[0]} : a[7:1] == 7'h04 ? {m_tgt[a[0]][6:0], 1'b0} : 8'h00;
    @(posedge sys_clk) #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    check8(reg_rdata, e, "read data");
  endtask : rd
  // event, id load and transaction strobes, one cycle each
  task automatic evt();
    @(posedge sys_clk) #1;
    seq_err_evt = 1'b1;
    @(posedge sys_clk) #1;
    seq_err_evt = 1'b0;
    if (!m_ctl[6]) m_flag = 1;
  endtask : evt
  task automatic rid(input logic [6:0] v);
    @(posedge sys_clk) #1;
    {rid_valid, rid_value} = {1'b1, v};
    @(posedge sys_clk) #1;
    rid_valid = 1'b0;
    if (!m_hold) m_rid = v;
  endtask : rid
  task automatic txn(input logic [6:0] a, input logic v, input logic [6:0] t);
    @(posedge sys_clk) #1;
    {txn_valid, txn_addr} = {1'b1, a};
    @(posedge sys_clk) #1;
    txn_valid = 1'b0;
    check8({7'h0, fwd_valid}, {7'h0, v}, "forward strobe");
    if (v) check8({1'b0, fwd_addr}, {1'b0, t}, "forward address");
  endtask : txn
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_wr_remote, reg_rd, seq_err_evt, rid_valid} = '0;
    {rid_value, pass_through, alias0, alias1, txn_valid, txn_addr} = '0;
    {sda_tx_en, sda_tx_bit, host_scl, host_sda} = '0;
    void'($urandom(32'h1170));
    repeat (8) @(posedge sys_clk);
    #1 rstn = 1'b1;
    for (int a = 6; a < 11; a++) rd(8'(a));
    wr(OFS_BUS_CTRL_TWO, 8'hb9, 1'b0);
    rd(OFS_BUS_CTRL_TWO);
    wr(OFS_BUS_CTRL_TWO, 8'h04, 1'b0);
    wr(OFS_TGT_ADDR_0, 8'($urandom), 1'b1);
    wr(OFS_BUS_CTRL_TWO, 8'h00, 1'b1);
    wr(OFS_TGT_ADDR_1, 8'($urandom), 1'b0);
    rd(OFS_TGT_ADDR_0);
    rd(OFS_TGT_ADDR_1);
    wr(OFS_BUS_CTRL_TWO, 8'h00, 1'b0);
    wr(OFS_TGT_ADDR_0, 8'($urandom), 1'b1);
    rd(OFS_TGT_ADDR_0);
    evt();
    rd(OFS_BUS_CTRL_TWO);
    wr(OFS_BUS_CTRL_TWO, 8'h40, 1'b0);
    evt();
    rd(OFS_BUS_CTRL_TWO);
    wr(OFS_BUS_CTRL_TWO, 8'h00, 1'b0);
    rd(OFS_BUS_CTRL_TWO);
    evt();
    rd(OFS_BUS_CTRL_TWO);
    rid(7'($urandom));
    wr(OFS_REMOTE_IDENT, 8'($urandom) & 8'hfe, 1'b0);
    rd(OFS_REMOTE_IDENT);
    wr(OFS_REMOTE_IDENT, 8'($urandom) | 8'h01, 1'b0);
    rid(7'($urandom));
    rd(OFS_REMOTE_IDENT);
    pass_through = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      alias0 = 7'($urandom);
      alias1 = alias0 ^ 7'h01;
      wr(OFS_TGT_ADDR_0, 8'($urandom), 1'b0);
      wr(OFS_TGT_ADDR_1, 8'($urandom), 1'b0);
      txn(alias0, 1'b1, 7'(m_tgt[0]));
      txn(alias1, 1'b1, 7'(m_tgt[1]));
      txn(alias0 ^ 7'h40, 1'b0, 7'h00);
    end
    pass_through = 1'b0;
    txn(alias0, 1'b0, 7'h00);
    // sda delay per code, watchdog held off meanwhile
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_BUS_CTRL_TWO, 8'(c * 8 + 1), 1'b0);
      {sda_tx_en, host_scl} = 2'b11;
      wait_for(2, 200, n);
      checkn(n, SDA_DLY_BASE_CYC + c * SDA_DLY_STEP_CYC + 1,
             SDA_DLY_BASE_CYC + c * SDA_DLY_STEP_CYC + 1, "sda delay");
      {sda_tx_en, host_scl} = 2'b00;
      wait_for(4, 200, n);
    end
    // quiet bus with sda high, fast then slow timeout
    for (int f = 1; f >= 0; f--)
    begin
      wr(OFS_BUS_CTRL_TWO, 8'(f * 2), 1'b0);
      host_scl = 1'b1;
      @(posedge sys_clk) #1;
      host_scl = 1'b0;
      wait_for(0, 100, n);
      checkn(n, (f ? SHORT : LONG) - 1, (f ? SHORT : LONG) + 3, "free");
    end
    // hung bus: nine recovery clocks, then a fresh period
    host_sda = 1'b1;
    wait_for(1, 200, n);
    checkn(n, LONG - 1, LONG + 3, "hung timeout");
    for (int i = 0; i < 9; i++)
    begin
      wait_for(3, 1100, n);
      checkn(n, RECOV_HALF_CYC, RECOV_HALF_CYC, "scl low");
      wait_for(1, 1100, n);
    end
    checkn(n, RECOV_HALF_CYC + LONG, RECOV_HALF_CYC + LONG, "after nine clocks");
    wr(OFS_BUS_CTRL_TWO, 8'h01, 1'b0);
    @(posedge sys_clk) #1;
    check8({7'h0, scl_oe_n}, 8'h01, "recovery abort");
    n = 0;
    for (int i = 0; i < 300; i++)
    begin
      host_sda = i < 150;
      @(posedge sys_clk) #1;
      n += (bus_free !== 1'b0) || (scl_oe_n !== 1'b1);
    end
    checkn(n, 0, 0, "disabled watchdog");
    results();
  end
endmodule : ctrl_channel_bus_config_tb
